// >>> core/risc_top.sv
// reference input selection and input buffer configuration
`timescale 1ns/10ps
module risc_top (
    input  wire logic                   clk_sys_i,    // system clock
    input  wire logic                   rst_b_i,      // sync reset, low
    input  wire logic                   reg_wr_i,     // register write strobe
    input  wire logic                   reg_rd_i,     // register read strobe
    input  wire logic [7:0]             reg_addr_i,   // register address
    input  wire logic [7:0]             reg_wdata_i,  // register write data
    output logic [7:0]                  reg_rdata_o,  // register read data
    input  wire logic [1:0]             ref_pin_i,    // choice pin level code
    input  wire logic                   pri_ok_i,     // primary detected
    input  wire logic                   sec_ok_i,     // secondary detected
    output risc_pkg::risc_pll_stat_t    pll1_stat_o,  // pll1 selection
    output risc_pkg::risc_pll_stat_t    pll2_stat_o,  // pll2 selection
    output risc_pkg::risc_term_t        term_o,       // termination switches
    output logic [1:0]                  bias_en_o,    // bias enable sec/pri
    output logic [3:0]                  fmt_o,        // input format bits
    output logic                        xtal_path_en_o // crystal path enable
);
    import risc_pkg::*;

    logic [7:0] term_bias_ff;
    logic [7:0] fmt_sel_ff;
    logic [7:0] sw_ctrl_ff;
    logic [7:0] rdata_ff;
    logic [1:0] bias_ff;
    logic [3:0] fmt_ff;
    logic       xtal_en_ff;
    logic       boot_sec_ff;
    risc_term_t term_ff;
    risc_pin_t  pin_lvl;
    logic       pll1_auto;
    logic       pll2_auto;
    logic       pll1_sec;
    logic       pll2_sec;
    logic       back_on_pri;
    risc_pll_stat_t st1;
    risc_pll_stat_t st2;

    // decode of the level code presented by the pin sampler
    function automatic risc_pin_t pin_decode(input logic [1:0] code);
        if (code == 2'h0) begin
            pin_decode = RISC_PIN_LOW;
        end else if (code == 2'h3) begin
            pin_decode = RISC_PIN_HIGH;
        end else begin
            pin_decode = RISC_PIN_MID;
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // registers

    // 0x33 bit 2 keeps the crystal path up; its other bits are storage only
    // writes to 0x34 and to unmapped offsets are dropped
    always_ff @(posedge clk_sys_i) begin
        if (!rst_b_i) begin
            term_bias_ff <= RISC_TERM_BIAS_RST;
            fmt_sel_ff   <= RISC_FMT_SEL_RST;
            sw_ctrl_ff   <= RISC_SWITCH_CTRL_RST;
        end else if (reg_wr_i) begin
            if (reg_addr_i == RISC_TERM_BIAS_OFS) begin
                term_bias_ff <= reg_wdata_i;
            end else if (reg_addr_i == RISC_FMT_SEL_OFS) begin
                fmt_sel_ff <= reg_wdata_i;
            end else if (reg_addr_i == RISC_SWITCH_CTRL_OFS) begin
                sw_ctrl_ff <= reg_wdata_i;
            end
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (!rst_b_i) begin
            rdata_ff <= 8'h00;
        end else if (reg_rd_i) begin
            // status is read-only; unmapped addresses read as zero
            if (reg_addr_i == RISC_TERM_BIAS_OFS) begin
                rdata_ff <= term_bias_ff;
            end else if (reg_addr_i == RISC_FMT_SEL_OFS) begin
                rdata_ff <= fmt_sel_ff;
            end else if (reg_addr_i == RISC_SWITCH_CTRL_OFS) begin
                rdata_ff <= sw_ctrl_ff;
            end else if (reg_addr_i == RISC_STATUS_OFS) begin
                rdata_ff <= {st2, st1};
            end else begin
                rdata_ff <= 8'h00;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // selection decode

    assign pin_lvl = pin_decode(ref_pin_i);

    // pair 01 hands the choice to the pin; pll2 joins auto only at high
    always_comb begin
        pll1_auto = 1'b0;
        pll1_sec  = 1'b0;
        case (fmt_sel_ff[1:0])
            RISC_SEL_AUTO: begin
                pll1_auto = 1'b1;
            end
            RISC_SEL_PIN: begin
                pll1_auto = (pin_lvl != RISC_PIN_LOW);
            end
            RISC_SEL_FIXPRI: begin
                pll1_sec = 1'b0;
            end
            default: begin
                pll1_sec = 1'b1;
            end
        endcase
    end

    always_comb begin
        pll2_auto = 1'b0;
        pll2_sec  = 1'b0;
        case (fmt_sel_ff[3:2])
            RISC_SEL_AUTO: begin
                pll2_auto = 1'b1;
            end
            RISC_SEL_PIN: begin
                pll2_auto = (pin_lvl == RISC_PIN_HIGH);
                pll2_sec  = (pin_lvl != RISC_PIN_HIGH);
            end
            RISC_SEL_FIXPRI: begin
                pll2_sec = 1'b0;
            end
            default: begin
                pll2_sec = 1'b1;
            end
        endcase
    end

    // both muxes watch the same detectors; only their mode inputs differ
    risc_mux_ctrl u_mux1 (
        .clk_sys_i (clk_sys_i),
        .rst_b_i   (rst_b_i),
        .auto_i    (pll1_auto),
        .man_sec_i (pll1_sec),
        .pri_ok_i  (pri_ok_i),
        .sec_ok_i  (sec_ok_i),
        .stat_o    (st1)
    );

    risc_mux_ctrl u_mux2 (
        .clk_sys_i (clk_sys_i),
        .rst_b_i   (rst_b_i),
        .auto_i    (pll2_auto),
        .man_sec_i (pll2_sec),
        .pri_ok_i  (pri_ok_i),
        .sec_ok_i  (sec_ok_i),
        .stat_o    (st2)
    );

    ////////////////////////////////////////////////////////////////////////
    // crystal path shutdown after switchover back to primary

    // boot_sec_ff remembers that a pll has run from the secondary; it is
    // cleared only by reset, so clearing keep later drops the path as soon as back_on_pri holds
    assign back_on_pri = (st1.auto_mode || st2.auto_mode) &&
                         !st1.use_secondary && !st2.use_secondary;

    always_ff @(posedge clk_sys_i) begin
        if (!rst_b_i) begin
            boot_sec_ff <= 1'b0;
            xtal_en_ff  <= 1'b1;
        end else begin
            if (st1.use_secondary || st2.use_secondary) begin
                boot_sec_ff <= 1'b1;
            end
            if (sw_ctrl_ff[RISC_KEEP_XTAL_BIT]) begin
                xtal_en_ff <= 1'b1;
            end else if (boot_sec_ff && back_on_pri) begin
                xtal_en_ff <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // buffer configuration outputs

    always_ff @(posedge clk_sys_i) begin
        if (!rst_b_i) begin
            term_ff <= '0;
            bias_ff <= 2'h0;
            fmt_ff  <= 4'h0;
        end else begin
            // each pair is {secondary, primary}; ac bias follows the bias bits
            term_ff.low_swing_term_switch     <= term_bias_ff[3:2];
            term_ff.current_steer_term_switch <= term_bias_ff[5:4];
            term_ff.ac_bias_switch            <= term_bias_ff[1:0];
            bias_ff <= term_bias_ff[1:0];
            fmt_ff[1:0] <= fmt_sel_ff[RISC_FMT_PRI_LO +: 2];
            fmt_ff[3:2] <= fmt_sel_ff[RISC_FMT_SEC_LO +: 2];
        end
    end

    assign reg_rdata_o    = rdata_ff;
    assign pll1_stat_o    = st1;
    assign pll2_stat_o    = st2;
    assign term_o         = term_ff;
    assign bias_en_o      = bias_ff;
    assign fmt_o          = fmt_ff;
    assign xtal_path_en_o = xtal_en_ff;
endmodule

// >>> core/risc_pkg.sv
// package for the reference input selection and buffer configuration block
package risc_pkg;

    localparam logic [7:0] RISC_TERM_BIAS_OFS   = 8'h1d;
    localparam logic [7:0] RISC_FMT_SEL_OFS     = 8'h32;
    localparam logic [7:0] RISC_SWITCH_CTRL_OFS = 8'h33;
    localparam logic [7:0] RISC_STATUS_OFS      = 8'h34;

    localparam logic [7:0] RISC_TERM_BIAS_RST   = 8'h00;
    localparam logic [7:0] RISC_FMT_SEL_RST     = 8'h00;
    localparam logic [7:0] RISC_SWITCH_CTRL_RST = 8'h04;

    localparam int RISC_KEEP_XTAL_BIT = 2;
    localparam int RISC_FMT_PRI_LO    = 4;
    localparam int RISC_FMT_SEC_LO    = 6;

    localparam logic [1:0] RISC_SEL_AUTO   = 2'h0;
    localparam logic [1:0] RISC_SEL_PIN    = 2'h1;
    localparam logic [1:0] RISC_SEL_FIXPRI = 2'h2;
    localparam logic [1:0] RISC_SEL_FIXSEC = 2'h3;

    // three-state pin levels
    typedef enum logic [1:0] {
        RISC_PIN_LOW  = 2'h0,
        RISC_PIN_MID  = 2'h1,
        RISC_PIN_HIGH = 2'h3
    } risc_pin_t;

    // per-pll mux state, gray along pri -> sec -> wait
    typedef enum logic [1:0] {
        RISC_ON_PRI  = 2'h0,
        RISC_ON_SEC  = 2'h1,
        RISC_WAIT    = 2'h3
    } risc_mux_t;

    typedef struct packed {
        logic       auto_mode;
        logic       use_secondary;
        logic       loss_of_signal_flag;
        logic       outputs_enabled;
    } risc_pll_stat_t;

    typedef struct packed {
        logic [1:0] low_swing_term_switch;
        logic [1:0] current_steer_term_switch;
        logic [1:0] ac_bias_switch;
    } risc_term_t;

endpackage

// >>> core/risc_mux_ctrl.sv
// one pll's smart input mux: automatic or manual reference choice
`timescale 1ns/10ps
module risc_mux_ctrl (
    input  wire logic                      clk_sys_i,  // system clock
    input  wire logic                      rst_b_i,    // sync reset, low
    input  wire logic                      auto_i,     // automatic mode
    input  wire logic                      man_sec_i,  // manual: secondary
    input  wire logic                      pri_ok_i,   // primary present
    input  wire logic                      sec_ok_i,   // secondary present
    output risc_pkg::risc_pll_stat_t       stat_o      // selection status
);
    import risc_pkg::*;

    risc_mux_t      state_ff;
    risc_mux_t      nxt_state;
    risc_pll_stat_t stat_ff;

    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            RISC_ON_PRI: begin
                if (!pri_ok_i && sec_ok_i) begin
                    nxt_state = RISC_ON_SEC;
                end else if (!pri_ok_i) begin
                    nxt_state = RISC_WAIT;
                end
            end
            RISC_ON_SEC: begin
                if (pri_ok_i) begin
                    nxt_state = RISC_ON_PRI;
                end else if (!sec_ok_i) begin
                    nxt_state = RISC_WAIT;
                end
            end
            RISC_WAIT: begin
                if (pri_ok_i) begin
                    nxt_state = RISC_ON_PRI;
                end else if (sec_ok_i) begin
                    nxt_state = RISC_ON_SEC;
                end
            end
            default: nxt_state = RISC_ON_PRI;
        endcase
        // manual mode holds the fsm parked on primary preference
        if (!auto_i) begin
            nxt_state = RISC_ON_PRI;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (!rst_b_i) begin
            state_ff <= RISC_ON_PRI;
        end else begin
            state_ff <= nxt_state;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (!rst_b_i) begin
            stat_ff <= '0;
        end else begin
            stat_ff.auto_mode <= auto_i;
            stat_ff.use_secondary <= auto_i ? (nxt_state != RISC_ON_PRI)
                                            : man_sec_i;
            stat_ff.loss_of_signal_flag <= !pri_ok_i && !sec_ok_i;
            stat_ff.outputs_enabled <= pri_ok_i || sec_ok_i;
        end
    end

    assign stat_o = stat_ff;
endmodule

// >>> verif/risc_top_monitor.sv
// concurrent checks on selection, buffer config and crystal path
`timescale 1ns/10ps
module risc_top_monitor (
    input wire logic                clk_sys_i,     // system clock
    input wire logic                rst_b_i,       // sync reset, low
    input wire logic                reg_wr_i,      // write strobe
    input wire logic [7:0]          reg_addr_i,    // address
    input wire logic [7:0]          reg_wdata_i,   // write data
    input wire logic [1:0]          ref_pin_i,     // pin level code
    input wire logic                pri_ok_i,      // primary present
    input wire logic                sec_ok_i,      // secondary present
    input wire risc_pkg::risc_pll_stat_t pll1_stat_o, // pll1 status
    input wire risc_pkg::risc_pll_stat_t pll2_stat_o, // pll2 status
    input wire risc_pkg::risc_term_t term_o,       // switches
    input wire logic [1:0]          bias_en_o,     // bias enables
    input wire logic                xtal_path_en_o // crystal path
);
    import risc_pkg::*;
    ////////////////////////////////////////////////////////////////////
    logic [3:0] sel_ff;
    logic       keep_ff;
    logic [1:0] quiet_ff;
    logic [3:0] last_ff;
    logic       settled;
    logic [1:0] e1;
    logic [1:0] e2;
    // expected {auto, secondary} of one pll from its pair and the pin
    function automatic logic [1:0] xs(input logic n, input logic [1:0] s,
                                      input logic [1:0] p);
        if (s == RISC_SEL_AUTO) return 2'b10;
        if (s == RISC_SEL_FIXPRI) return 2'b00;
        if (s == RISC_SEL_FIXSEC) return 2'b01;
        if (p == 2'h0) return {1'b0, n};
        return (p == 2'h3 || !n) ? 2'b10 : 2'b01;
    endfunction
    assign e1 = xs(1'b0, sel_ff[1:0], ref_pin_i);
    assign e2 = xs(1'b1, sel_ff[3:2], ref_pin_i);
    always_ff @(posedge clk_sys_i) begin
        if (!rst_b_i) begin
            sel_ff  <= 4'h0;
            keep_ff <= 1'b1;
        end else if (reg_wr_i && reg_addr_i == RISC_FMT_SEL_OFS) begin
            sel_ff  <= reg_wdata_i[3:0];
        end else if (reg_wr_i && reg_addr_i == RISC_SWITCH_CTRL_OFS) begin
            keep_ff <= reg_wdata_i[RISC_KEEP_XTAL_BIT];
        end
    end
    // last sampled selection inputs
    always_ff @(posedge clk_sys_i) begin
        last_ff <= {ref_pin_i, pri_ok_i, sec_ok_i};
    end
    // cycles since the selection inputs last moved, saturating at 3
    always_ff @(posedge clk_sys_i) begin
        if (!rst_b_i || (reg_wr_i && reg_addr_i == RISC_FMT_SEL_OFS) ||
            {ref_pin_i, pri_ok_i, sec_ok_i} != last_ff) begin
            quiet_ff <= 2'h0;
        end else if (quiet_ff != 2'h3) begin
            quiet_ff <= quiet_ff + 2'h1;
        end
    end
    // status lags its inputs by one edge, so a move seen now must not count
    assign settled = quiet_ff == 2'h3 &&
                     {ref_pin_i, pri_ok_i, sec_ok_i} == last_ff;
    ////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!rst_b_i);
    chk_bias_follow: assert property (
        (reg_wr_i && reg_addr_i == RISC_TERM_BIAS_OFS) ##1 !reg_wr_i
        |-> ##1 bias_en_o == $past(reg_wdata_i[1:0], 2))
        else $error("bias enables do not follow the write");
    chk_term_follow: assert property (
        (reg_wr_i && reg_addr_i == RISC_TERM_BIAS_OFS) ##1 !reg_wr_i
        |-> ##1 term_o == {$past(reg_wdata_i[3:2], 2),
            $past(reg_wdata_i[5:4], 2), $past(reg_wdata_i[1:0], 2)})
        else $error("termination switches do not follow the write");
    chk_sel_mode: assert property (
        settled |-> {pll1_stat_o.auto_mode,
            pll2_stat_o.auto_mode} == {e1[1], e2[1]})
        else $error("mux mode does not match selection");
    chk_sel_manual: assert property (
        settled |-> (e1[1] || pll1_stat_o.use_secondary == e1[0])
        && (e2[1] || pll2_stat_o.use_secondary == e2[0]))
        else $error("manual reference does not match selection");
    chk_auto_primary: assert property (
        settled && e1[1] && pri_ok_i |-> !pll1_stat_o.use_secondary
        && !pll1_stat_o.loss_of_signal_flag && pll1_stat_o.outputs_enabled)
        else $error("auto mux not on primary while primary present");
    chk_auto_failover: assert property (
        settled && e1[1] && !pri_ok_i && sec_ok_i
        |-> pll1_stat_o.use_secondary && !pll1_stat_o.loss_of_signal_flag)
        else $error("auto mux did not fail over to secondary");
    chk_auto_loss: assert property (
        settled && e1[1] && !pri_ok_i && !sec_ok_i
        |-> pll1_stat_o.loss_of_signal_flag && !pll1_stat_o.outputs_enabled)
        else $error("total loss not flagged");
    chk_xtal_keep: assert property (
        $fell(xtal_path_en_o) |-> !$past(keep_ff))
        else $error("crystal path dropped while keep bit set");
    chk_xtal_restore: assert property (
        reg_wr_i && reg_addr_i == RISC_SWITCH_CTRL_OFS &&
        reg_wdata_i[RISC_KEEP_XTAL_BIT] |-> ##[1:3] xtal_path_en_o)
        else $error("crystal path not restored by keep bit");
endmodule
bind risc_top risc_top_monitor u_mon (.*);

// >>> verif/risc_ref_model.sv
// reference sources seen through their presence detectors
`timescale 1ns/10ps
module risc_ref_model (
    input  wire logic clk_sys_i, // system clock
    input  wire logic pri_on_i,  // primary source running
    input  wire logic sec_on_i,  // secondary source running
    output logic      pri_ok_o,  // primary detected
    output logic      sec_ok_o   // secondary detected
);
    ////////////////////////////////////////////////////////////////////
    initial {pri_ok_o, sec_ok_o} = 2'b11;
    // detection lags the source by one control clock
    always @(posedge clk_sys_i) begin
        pri_ok_o <= pri_on_i;
        sec_ok_o <= sec_on_i;
    end
endmodule

// >>> verif/risc_top_tb.sv
// self-checking bench for reference selection and buffer config
`timescale 1ns/10ps
module risc_top_tb;
    import risc_pkg::*;
    logic           clk_sys_i, rst_b_i, reg_wr_i, reg_rd_i, pri_on, sec_on;
    logic [7:0]     reg_addr_i, reg_wdata_i, reg_rdata_o, d;
    logic [1:0]     ref_pin_i, bias_en_o;
    logic [3:0]     fmt_o;
    logic           pri_ok_i, sec_ok_i, xtal_path_en_o;
    risc_pll_stat_t pll1_stat_o, pll2_stat_o;
    risc_term_t     term_o;
    int             fail_count, num_checks, cyc;
    logic [3:0]  cfg [5] = '{4'hb, 4'hc, 4'ha, 4'h8, 4'h0};
    logic [15:0] sel [5] = '{16'h0b11, 16'h0504, 16'h0526, 16'h053a,
                             16'h000a};
    logic [9:0]  walk [4] = '{10'h1dd, 10'h0ee, 10'h299, 10'h399};
    risc_top dut (.*);
    risc_ref_model u_src (.clk_sys_i(clk_sys_i), .pri_on_i(pri_on),
        .sec_on_i(sec_on), .pri_ok_o(pri_ok_i), .sec_ok_o(sec_ok_i));
    ////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic w(input int n);
        repeat (n) @(posedge clk_sys_i);
        #1;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        w(1);
        reg_wr_i = 1'b1;
        reg_addr_i = a;
        reg_wdata_i = v;
        w(1);
        reg_wr_i = 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        w(1);
        reg_rd_i = 1'b1;
        reg_addr_i = a;
        w(1);
        reg_rd_i = 1'b0;
        chk(reg_rdata_o, exp);
    endtask
    task automatic run_walk();
        foreach (walk[i]) begin
            {pri_on, sec_on} = walk[i][9:8];
            w(6);
            chk({pll2_stat_o, pll1_stat_o}, walk[i][7:0]);
        end
    endtask
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////
    initial begin
        clk_sys_i = 1'b0;
        forever #5 clk_sys_i = ~clk_sys_i;
    end
    always @(posedge clk_sys_i) begin
        cyc++;
        if (cyc == 5000) begin
            fail_count++;
            $display("[FAIL] %0t run did not finish", $time);
            give_verdict();
        end
    end
    initial begin
        {reg_wr_i, reg_rd_i, pri_on, sec_on, rst_b_i} = 5'b00110;
        {reg_addr_i, reg_wdata_i, ref_pin_i} = 18'h0;
        w(6);
        rst_b_i = 1'b1;
        chk({7'h0, xtal_path_en_o}, 8'h01);
        chk({term_o, bias_en_o}, 8'h00);
        chk({pll2_stat_o, pll1_stat_o}, 8'h00);
        rd(RISC_TERM_BIAS_OFS, RISC_TERM_BIAS_RST);
        rd(RISC_FMT_SEL_OFS, RISC_FMT_SEL_RST);
        rd(RISC_SWITCH_CTRL_OFS, RISC_SWITCH_CTRL_RST);
        wr(8'h40, 8'hff);
        rd(8'h40, 8'h00);
        $display("test reset done");
        foreach (cfg[i]) begin
            d = {2'h0, {2{cfg[i][2]}}, {2{cfg[i][1]}}, {2{cfg[i][0]}}};
            wr(RISC_TERM_BIAS_OFS, d);
            wr(RISC_FMT_SEL_OFS, {{2{1'b0, cfg[i][3]}}, 4'h0});
            w(2);
            rd(RISC_TERM_BIAS_OFS, d);
            chk({term_o, bias_en_o}, {d[3:2], d[5:4], d[1:0], d[1:0]});
            chk({4'h0, fmt_o}, {4'h0, {2{1'b0, cfg[i][3]}}});
        end
        $display("test buffer done");
        for (int s = 0; s < 16; s++) begin
            wr(RISC_FMT_SEL_OFS, 8'(s));
            for (int p = 0; p < 4; p++) begin
                ref_pin_i = 2'(p);
                w(6);
            end
        end
        foreach (sel[i]) begin
            wr(RISC_FMT_SEL_OFS, sel[i][15:8]);
            ref_pin_i = sel[i][5:4];
            w(4);
            chk({4'h0, pll2_stat_o[3:2], pll1_stat_o[3:2]}, {4'h0, sel[i][3:0]});
        end
        rd(RISC_STATUS_OFS, 8'h99);
        $display("test select done");
        run_walk();
        chk({7'h0, xtal_path_en_o}, 8'h01);
        wr(RISC_SWITCH_CTRL_OFS, 8'h00);
        run_walk();
        chk({7'h0, xtal_path_en_o}, 8'h00);
        wr(RISC_SWITCH_CTRL_OFS, 8'h04);
        w(3);
        chk({7'h0, xtal_path_en_o}, 8'h01);
        $display("test switchover done");
        give_verdict();
    end
endmodule
